// File: core/omc_low_detect.sv
// low-level qualifier for the sleep toggle pin
// assumes the pin is already synchronous to i_clk_sys
module omc_low_detect #(
  parameter int unsigned LOW_CYCLES = 2000000,
  parameter int unsigned CNT_W      = 22
) (
  // clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_srst,
  // pin
  input  wire logic i_pin,
  // result
  output logic      o_fire
);

  logic [CNT_W-1:0] low_cnt;
  logic             fired;
  logic             at_end;

  // pulse once per low period, when it has lasted the full time
  assign at_end = (low_cnt == CNT_W'(LOW_CYCLES - 1));

  always_ff @(posedge i_clk_sys) begin
    if (i_srst || i_pin) begin
      low_cnt <= '0;
      fired   <= 1'b0;
      o_fire  <= 1'b0;
    end else begin
      o_fire <= at_end && !fired;
      if (at_end) begin
        fired <= 1'b1;
      end else begin
        low_cnt <= low_cnt + CNT_W'(1);
      end
    end
  end

endmodule : omc_low_detect

// File: core/omc_mode_ctrl.sv
// operating mode controller: mode state machine, audio routing and clock/analog enables
// assumes host commands arrive decoded as one-cycle strobes; scl and pins are synchronous
module omc_mode_ctrl
  import omc_pkg::*;
#(
  parameter int unsigned PIN_LOW_CYCLES = OMC_PIN_LOW_CYCLES,
  parameter int unsigned STANDBY_CYCLES = OMC_STANDBY_CYCLES,
  parameter int unsigned STAT_W         = 16
) (
  // clock and reset
  input  wire logic              i_clk_sys,
  input  wire logic              i_srst,
  // host command strobe and selected mode
  input  wire logic              i_cmd_valid,
  input  wire logic [2:0]        i_cmd_mode,
  input  wire logic              i_stat_clear,
  // pins and monitors
  input  wire logic              i_scl,
  input  wire logic              i_sleep_toggle_n,
  input  wire logic              i_ext_clk_ok,
  // audio samples in
  input  wire logic              i_mic_valid,
  input  wire logic [STAT_W-1:0] i_mic0,
  input  wire logic [STAT_W-1:0] i_mic1,
  input  wire logic [STAT_W-1:0] i_nr_out,
  // status
  output logic [2:0]             o_mode,
  // audio outputs
  output logic                   o_out_valid,
  output logic [STAT_W-1:0]      o_out_ch0,
  output logic [STAT_W-1:0]      o_out_ch1,
  // block enables
  output logic                   o_nr_enable,
  output logic                   o_analog_enable,
  output logic                   o_line_output_ch0,
  output logic                   o_line_output_ch1,
  output logic [1:0]             o_clk_sel,
  // statistics
  output logic [STAT_W-1:0]      o_peak_ch0,
  output logic [STAT_W-1:0]      o_peak_ch1
);

  // ********************************
  // state
  // ********************************
  // counters are sized from their end counts so compares never cut bits
  localparam int unsigned PIN_CNT_W = $clog2(PIN_LOW_CYCLES + 1);
  localparam int unsigned SB_CNT_W  = $clog2(STANDBY_CYCLES + 1);
  localparam int unsigned STAT_CH   = 2;

  omc_mode_t             mode;
  omc_mode_t             next_mode;
  logic                  sleep_by_pin;
  logic                  next_sleep_by_pin;
  logic                  scl_q;
  logic [SB_CNT_W-1:0]   sb_cnt;
  logic [SB_CNT_W-1:0]   next_sb_cnt;
  logic                  pin_fire;

  // ********************************
  // decode nets
  // ********************************
  logic                  cmd_active;
  logic                  cmd_bypass;
  logic                  cmd_lineout;
  logic                  cmd_sleep;
  logic                  scl_act;
  logic                  sb_timeout;
  logic                  clk_lost;
  logic                  in_boot;
  logic                  in_active;
  logic                  in_bypass;
  logic                  in_lineout;
  logic                  in_sleep;
  logic                  in_standby;

  // ********************************
  // pin qualifier
  // ********************************
  // a low shorter than the full time never reaches the state machine
  omc_low_detect #(
    .LOW_CYCLES (PIN_LOW_CYCLES),
    .CNT_W      (PIN_CNT_W)
  ) u_pin_low (
    .i_clk_sys  (i_clk_sys),
    .i_srst     (i_srst),
    .i_pin      (i_sleep_toggle_n),
    .o_fire     (pin_fire)
  );

  // ********************************
  // decode
  // ********************************
  assign cmd_active  = i_cmd_valid && (i_cmd_mode == OMC_CMD_ACTIVE);
  assign cmd_bypass  = i_cmd_valid && (i_cmd_mode == OMC_CMD_BYPASS);
  assign cmd_lineout = i_cmd_valid && (i_cmd_mode == OMC_CMD_LINEOUT);
  assign cmd_sleep   = i_cmd_valid && (i_cmd_mode == OMC_CMD_SLEEP);
  // scl edge seen from a registered copy; the pin is taken as already synchronous
  assign scl_act     = (i_scl != scl_q);
  assign sb_timeout  = (sb_cnt == SB_CNT_W'(STANDBY_CYCLES - 1));
  // the external clock matters only where the mode runs from it
  assign clk_lost    = !i_ext_clk_ok;

  // one flag per state, read by the output selects
  assign in_boot     = (mode == OMC_ST_BOOT);
  assign in_active   = (mode == OMC_ST_ACTIVE);
  assign in_bypass   = (mode == OMC_ST_BYPASS);
  assign in_lineout  = (mode == OMC_ST_LINEOUT);
  assign in_sleep    = (mode == OMC_ST_SLEEP);
  assign in_standby  = (mode == OMC_ST_STANDBY);

  // standby counter restarts on every entry, so each wake gets the full wait
  assign next_sb_cnt = in_standby ? (sb_cnt + SB_CNT_W'(1)) : '0;

  always_comb begin
    next_mode         = mode;
    next_sleep_by_pin = sleep_by_pin;
    case (mode)
      OMC_ST_BOOT: begin
        next_mode = OMC_ST_ACTIVE;
      end
      OMC_ST_ACTIVE: begin
        // clock loss first: without the clock nothing below can be trusted
        if (clk_lost) begin
          next_mode         = OMC_ST_SLEEP;
          next_sleep_by_pin = 1'b0;
        end else if (pin_fire) begin
          next_mode         = OMC_ST_SLEEP;
          next_sleep_by_pin = 1'b1;
        end else if (cmd_sleep) begin
          next_mode         = OMC_ST_SLEEP;
          next_sleep_by_pin = 1'b0;
        end else if (cmd_active) begin
          next_mode = OMC_ST_ACTIVE;
        end else if (cmd_bypass) begin
          next_mode = OMC_ST_BYPASS;
        end else if (cmd_lineout) begin
          next_mode = OMC_ST_LINEOUT;
        end
      end
      OMC_ST_BYPASS: begin
        // same exits as active; a repeated bypass command simply holds the mode
        if (clk_lost) begin
          next_mode         = OMC_ST_SLEEP;
          next_sleep_by_pin = 1'b0;
        end else if (pin_fire) begin
          next_mode         = OMC_ST_SLEEP;
          next_sleep_by_pin = 1'b1;
        end else if (cmd_sleep) begin
          next_mode         = OMC_ST_SLEEP;
          next_sleep_by_pin = 1'b0;
        end else if (cmd_active) begin
          next_mode = OMC_ST_ACTIVE;
        end else if (cmd_lineout) begin
          next_mode = OMC_ST_LINEOUT;
        end
      end
      OMC_ST_LINEOUT: begin
        // internal clock here, so a stopped external clock is no cause to sleep
        if (pin_fire) begin
          next_mode         = OMC_ST_SLEEP;
          next_sleep_by_pin = 1'b1;
        end else if (cmd_sleep) begin
          next_mode         = OMC_ST_SLEEP;
          next_sleep_by_pin = 1'b0;
        end else if (cmd_active) begin
          next_mode = OMC_ST_ACTIVE;
        end else if (cmd_bypass) begin
          next_mode = OMC_ST_BYPASS;
        end
      end
      OMC_ST_SLEEP: begin
        // wake methods are not mixed: only the one that put us to sleep wakes us
        if (sleep_by_pin) begin
          if (pin_fire) begin
            next_mode = OMC_ST_ACTIVE;
          end
        end else if (scl_act) begin
          next_mode = OMC_ST_STANDBY;
        end
      end
      OMC_ST_STANDBY: begin
        // a command beats a timeout that lands in the same cycle
        if (cmd_active) begin
          next_mode = OMC_ST_ACTIVE;
        end else if (cmd_bypass) begin
          next_mode = OMC_ST_BYPASS;
        end else if (cmd_lineout) begin
          next_mode = OMC_ST_LINEOUT;
        end else if (sb_timeout) begin
          next_mode         = OMC_ST_SLEEP;
          next_sleep_by_pin = 1'b0;
        end
      end
      default: begin
        next_mode = OMC_ST_BOOT;
      end
    endcase
  end

  // ********************************
  // registers
  // ********************************
  // mode and the way sleep was entered
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      mode         <= OMC_ST_BOOT;
      sleep_by_pin <= 1'b0;
    end else begin
      mode         <= next_mode;
      sleep_by_pin <= next_sleep_by_pin;
    end
  end

  // scl idles high, so the copy starts high and reset gives no false wake
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      scl_q <= 1'b1;
    end else begin
      scl_q <= i_scl;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      sb_cnt <= '0;
    end else begin
      sb_cnt <= next_sb_cnt;
    end
  end

  // ********************************
  // outputs
  // ********************************
  logic              route;
  logic              analog;
  logic [1:0]        clk_src;
  logic [STAT_W-1:0] chan_sel [STAT_CH];
  logic [STAT_W-1:0] chan_raw [STAT_CH];

  // processed audio leads on ch0 in active; ch1 always carries the raw second mic
  assign chan_sel[0] = in_active ? i_nr_out : i_mic0;
  assign chan_sel[1] = i_mic1;
  assign chan_raw[0] = i_mic0;
  assign chan_raw[1] = i_mic1;
  assign route       = in_active || in_bypass;
  // line-out keeps analog up for the preamps but leaves the external clock free
  assign clk_src     = in_lineout ? OMC_CLK_INT : (in_sleep ? OMC_CLK_LOW : OMC_CLK_EXT);
  assign analog      = !(in_sleep || in_standby || in_boot);

  // status follows the next state, so the host sees a change on the taking edge
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_mode <= OMC_ST_BOOT;
    end else begin
      o_mode <= next_mode;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_out_valid     <= 1'b0;
      o_nr_enable     <= 1'b0;
      o_analog_enable <= 1'b0;
      o_clk_sel       <= OMC_CLK_EXT;
    end else begin
      o_out_valid     <= route && i_mic_valid;
      o_nr_enable     <= in_active;
      o_analog_enable <= analog;
      o_clk_sel       <= clk_src;
    end
  end

  // ********************************
  // statistics
  // ********************************
  logic stat_en;

  assign stat_en = in_bypass && i_mic_valid;

  // ********************************
  // per channel outputs
  // ********************************
  for (genvar ch = 0; ch < STAT_CH; ch++) begin : g_chan
    logic [STAT_W-1:0] audio;
    logic              line_on;
    logic [STAT_W-1:0] peak;
    logic              take;
    logic              drop;

    // an arriving sample beats a clear in the same cycle
    assign take = stat_en && (i_stat_clear || (chan_raw[ch] > peak));
    assign drop = i_stat_clear && !stat_en;

    always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
        audio   <= '0;
        line_on <= 1'b0;
      end else begin
        audio   <= route ? chan_sel[ch] : '0;
        line_on <= in_lineout;
      end
    end

    // simple peak hold; the host clears it before a calibration run
    always_ff @(posedge i_clk_sys) begin
      if (i_srst || drop) begin
        peak <= '0;
      end else if (take) begin
        peak <= chan_raw[ch];
      end
    end
  end

  assign o_out_ch0         = g_chan[0].audio;
  assign o_out_ch1         = g_chan[1].audio;
  assign o_line_output_ch0 = g_chan[0].line_on;
  assign o_line_output_ch1 = g_chan[1].line_on;
  assign o_peak_ch0        = g_chan[0].peak;
  assign o_peak_ch1        = g_chan[1].peak;

endmodule : omc_mode_ctrl

// File: include/omc_pkg.sv
// package for the operating mode controller: mode codes, commands and timing
// assumes a 100 MHz system clock; the host command decoder lives elsewhere
package omc_pkg;

  // ********************************
  // modes and commands
  // ********************************
  typedef enum logic [2:0] {
    OMC_ST_BOOT    = 3'h0,
    OMC_ST_ACTIVE  = 3'h1,
    OMC_ST_BYPASS  = 3'h2,
    OMC_ST_LINEOUT = 3'h3,
    OMC_ST_SLEEP   = 3'h4,
    OMC_ST_STANDBY = 3'h5
  } omc_mode_t;

  // mode-change command codes as presented on i_cmd_mode
  localparam logic [2:0] OMC_CMD_ACTIVE  = 3'h1;
  localparam logic [2:0] OMC_CMD_BYPASS  = 3'h2;
  localparam logic [2:0] OMC_CMD_LINEOUT = 3'h3;
  localparam logic [2:0] OMC_CMD_SLEEP   = 3'h4;

  // clock source select codes
  localparam logic [1:0] OMC_CLK_EXT  = 2'h0;
  localparam logic [1:0] OMC_CLK_INT  = 2'h1;
  localparam logic [1:0] OMC_CLK_LOW  = 2'h2;

  // ********************************
  // timing
  // ********************************
  localparam int unsigned OMC_CLK_HZ          = 100000000;
  localparam int unsigned OMC_PIN_LOW_MS      = 20;
  localparam int unsigned OMC_PIN_LOW_CYCLES  = OMC_CLK_HZ / 1000 * OMC_PIN_LOW_MS;
  localparam int unsigned OMC_STANDBY_US      = 1000;
  localparam int unsigned OMC_STANDBY_CYCLES  = OMC_CLK_HZ / 1000000 * OMC_STANDBY_US;

endpackage : omc_pkg

// File: verification/omc_host.sv
// host model: decoded mode commands, scl activity, sleep toggle pin
// assumes all drive happens at the falling edge of i_clk_sys
module omc_host
  import omc_pkg::*;
(
  // clock and status
  input  wire logic       i_clk_sys,
  input  wire logic [2:0] i_mode,
  // host drive
  output logic            o_cmd_valid,
  output logic [2:0]      o_cmd_mode,
  output logic            o_scl,
  output logic            o_sleep_toggle_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********************************
  // host actions
  // ********************************
  initial begin
    o_cmd_valid = 1'h0;
    o_cmd_mode = 3'h7;
    o_scl = 1'h1;
    o_sleep_toggle_n = 1'h1;
  end
  task automatic send(input logic [2:0] m);
    @(negedge i_clk_sys);
    o_cmd_valid = 1'h1;
    o_cmd_mode = m;
    @(negedge i_clk_sys);
    o_cmd_valid = 1'h0;
    o_cmd_mode = ~m;
  endtask : send
  // wake by scl change, then poll status for standby (bounded)
  task automatic wake;
    @(negedge i_clk_sys);
    o_scl = 1'h0;
    @(negedge i_clk_sys);
    o_scl = 1'h1;
    for (int k = 0; k < 20 && i_mode !== OMC_ST_STANDBY; k++) @(negedge i_clk_sys);
  endtask : wake
  task automatic pin(input int n);
    @(negedge i_clk_sys);
    o_sleep_toggle_n = 1'h0;
    repeat (n) @(negedge i_clk_sys);
    o_sleep_toggle_n = 1'h1;
  endtask : pin
endmodule : omc_host

// File: verification/omc_mode_ctrl_sva.sv
// checker for the mode controller: mode moves, enables, routing
// assumes it is bound onto the controller ports
module omc_mode_ctrl_sva
  import omc_pkg::*;
#(parameter int unsigned STAT_W = 16) (
  // clock, reset, host side
  input wire logic              i_clk_sys,
  input wire logic              i_srst,
  input wire logic              i_cmd_valid,
  input wire logic [2:0]        i_cmd_mode,
  input wire logic              i_sleep_toggle_n,
  input wire logic              i_ext_clk_ok,
  // audio
  input wire logic              i_mic_valid,
  input wire logic [STAT_W-1:0] i_mic0,
  input wire logic [STAT_W-1:0] i_mic1,
  input wire logic [STAT_W-1:0] i_nr_out,
  input wire logic              o_out_valid,
  input wire logic [STAT_W-1:0] o_out_ch0,
  input wire logic [STAT_W-1:0] o_out_ch1,
  // mode and enables
  input wire logic [2:0]        o_mode,
  input wire logic              o_nr_enable,
  input wire logic              o_analog_enable,
  input wire logic              o_line_output_ch0,
  input wire logic              o_line_output_ch1,
  input wire logic [1:0]        o_clk_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********************************
  // properties
  // ********************************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  wire act = o_mode == OMC_ST_ACTIVE;
  wire byp = o_mode == OMC_ST_BYPASS;
  wire lout = o_mode == OMC_ST_LINEOUT;
  wire slp = o_mode == OMC_ST_SLEEP;
  // outputs lag the mode by one cycle, hence |=>
  AST_BOOT: assert property ($fell(i_srst) |=> act)
    else $error("mode not active after reset");
  AST_CMD_ACT: assert property (i_cmd_valid && i_cmd_mode == OMC_CMD_ACTIVE && i_ext_clk_ok
    && i_sleep_toggle_n && !slp && o_mode != OMC_ST_BOOT |=> act) else $error("active command lost");
  AST_ACT_OUT: assert property (act && i_mic_valid |=> o_out_valid && o_nr_enable
    && o_out_ch0 == $past(i_nr_out) && o_out_ch1 == $past(i_mic1)) else $error("active routing wrong");
  AST_BYP_IN: assert property ($changed(o_mode) && byp |-> $past(i_cmd_valid)
    && $past(i_cmd_mode) == OMC_CMD_BYPASS) else $error("bypass without command");
  AST_BYP_OUT: assert property (byp && i_mic_valid |=> o_out_valid && !o_nr_enable
    && o_out_ch0 == $past(i_mic0) && o_out_ch1 == $past(i_mic1)) else $error("bypass routing wrong");
  AST_LOUT: assert property (lout |=> o_line_output_ch0 && o_line_output_ch1
    && o_clk_sel == OMC_CLK_INT && !o_nr_enable) else $error("line-out enables wrong");
  AST_LOUT_CLK: assert property (lout && !i_ext_clk_ok && !i_cmd_valid && i_sleep_toggle_n
    |=> lout) else $error("line-out left on clock loss");
  AST_CLK_LOSS: assert property ((act || byp) && !i_ext_clk_ok |=> slp)
    else $error("clock loss did not force sleep");
  AST_SLP_OUT: assert property (slp |=> !o_analog_enable && !o_nr_enable
    && o_clk_sel == OMC_CLK_LOW) else $error("sleep enables wrong");
  AST_STBY_IN: assert property (o_mode == OMC_ST_STANDBY && $past(o_mode) != OMC_ST_STANDBY
    |-> $past(o_mode) == OMC_ST_SLEEP) else $error("standby not from sleep");
  COV_BYP: cover property (act ##1 byp);
  COV_STBY: cover property (o_mode == OMC_ST_STANDBY);
  COV_LOUT: cover property (lout && !i_ext_clk_ok);
endmodule : omc_mode_ctrl_sva

bind omc_mode_ctrl omc_mode_ctrl_sva #(.STAT_W(STAT_W)) u_sva (.i_clk_sys, .i_srst, .i_cmd_valid,
  .i_cmd_mode, .i_sleep_toggle_n, .i_ext_clk_ok, .i_mic_valid, .i_mic0, .i_mic1, .i_nr_out, .o_out_valid,
  .o_out_ch0, .o_out_ch1, .o_mode, .o_nr_enable, .o_analog_enable, .o_line_output_ch0, .o_line_output_ch1,
  .o_clk_sel);

// File: verification/tb.sv
// self-checking bench for the mode controller with a host model
// assumes short pin and standby counts set by parameter
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import omc_pkg::*;
  localparam int unsigned PL = 20;
  localparam int unsigned SB = 50;
  logic clk, srst, cv, scl, sln, clk_ok, mv, clr, ov, nre, ane, l0, l1;
  logic [2:0] cm, mode;
  logic [1:0] cs;
  logic [15:0] m0, m1, nr, c0, c1, p0, p1, pk0, pk1;
  int n_errors = 0;
  int cmp_count = 0;
  omc_host host (.i_clk_sys(clk), .i_mode(mode), .o_cmd_valid(cv), .o_cmd_mode(cm), .o_scl(scl),
    .o_sleep_toggle_n(sln));
  omc_mode_ctrl #(.PIN_LOW_CYCLES(PL), .STANDBY_CYCLES(SB)) dut (.i_clk_sys(clk), .i_srst(srst),
    .i_cmd_valid(cv), .i_cmd_mode(cm), .i_stat_clear(clr), .i_scl(scl), .i_sleep_toggle_n(sln),
    .i_ext_clk_ok(clk_ok), .i_mic_valid(mv), .i_mic0(m0), .i_mic1(m1), .i_nr_out(nr), .o_mode(mode),
    .o_out_valid(ov), .o_out_ch0(c0), .o_out_ch1(c1), .o_nr_enable(nre), .o_analog_enable(ane),
    .o_line_output_ch0(l0), .o_line_output_ch1(l1), .o_clk_sel(cs), .o_peak_ch0(p0), .o_peak_ch1(p1));
  // ********************************
  // helpers
  // ********************************
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  function automatic logic [15:0] mx(input logic [15:0] a, b);
    return a > b ? a : b;
  endfunction : mx
  task automatic chk(input string s, input logic [15:0] e, g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask : w
  task automatic go(input logic [2:0] m, e);
    host.send(m);
    chk("mode", e, mode);
  endtask : go
  // positive samples keep a signed or unsigned peak reading the same
  task automatic samp(input logic act);
    logic [15:0] a, b, n;
    a = 16'($urandom) & 16'h7fff;
    b = 16'($urandom) & 16'h7fff;
    n = 16'($urandom);
    @(negedge clk);
    {m0, m1, nr, mv} = {a, b, n, 1'h1};
    @(negedge clk);
    {m0, m1, nr, mv} = {~a, ~b, ~n, 1'h0};
    chk("valid", 16'h1, ov);
    chk("ch0", act ? n : a, c0);
    chk("ch1", b, c1);
    pk0 = mx(pk0, a);
    pk1 = mx(pk1, b);
  endtask : samp
  task automatic final_report;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report
  initial begin
    #100000;
    n_errors++;
    final_report();
  end
  // ********************************
  // scenarios
  // ********************************
  initial begin
    void'($urandom(59241));
    {srst, clk_ok, mv, clr, m0, m1, nr, pk0, pk1} = {4'hc, 80'h0};
    w(4);
    srst = 1'h0;
    w(2);
    chk("mode", OMC_ST_ACTIVE, mode);
    repeat (3) samp(1'h1);
    go(OMC_CMD_BYPASS, OMC_ST_BYPASS);
    clr = 1'h1;
    w(1);
    {clr, pk0, pk1} = 33'h0;
    repeat (4) samp(1'h0);
    chk("peak0", pk0, p0);
    chk("peak1", pk1, p1);
    go(OMC_CMD_LINEOUT, OMC_ST_LINEOUT);
    w(1);
    chk("line", 16'h3, {l1, l0});
    chk("analog", 16'h1, ane);
    chk("clk", OMC_CLK_INT, cs);
    clk_ok = 1'h0;
    w(5);
    chk("mode", OMC_ST_LINEOUT, mode);
    clk_ok = 1'h1;
    go(OMC_CMD_ACTIVE, OMC_ST_ACTIVE);
    go(OMC_CMD_SLEEP, OMC_ST_SLEEP);
    w(1);
    chk("en", 16'h0, {ane, nre});
    chk("clk", OMC_CLK_LOW, cs);
    go(OMC_CMD_BYPASS, OMC_ST_SLEEP);
    host.pin(PL + 2);
    w(3);
    chk("mode", OMC_ST_SLEEP, mode);
    host.wake();
    chk("mode", OMC_ST_STANDBY, mode);
    go(OMC_CMD_BYPASS, OMC_ST_BYPASS);
    go(OMC_CMD_SLEEP, OMC_ST_SLEEP);
    host.wake();
    w(SB + 5);
    chk("mode", OMC_ST_SLEEP, mode);
    host.wake();
    go(OMC_CMD_ACTIVE, OMC_ST_ACTIVE);
    host.pin(PL - 4);
    w(3);
    chk("mode", OMC_ST_ACTIVE, mode);
    host.pin(PL + 2);
    w(3);
    chk("mode", OMC_ST_SLEEP, mode);
    host.wake();
    chk("mode", OMC_ST_SLEEP, mode);
    host.pin(PL + 2);
    w(3);
    chk("mode", OMC_ST_ACTIVE, mode);
    clk_ok = 1'h0;
    w(3);
    chk("mode", OMC_ST_SLEEP, mode);
    {clk_ok, srst} = 2'h3;
    w(2);
    srst = 1'h0;
    w(2);
    chk("mode", OMC_ST_ACTIVE, mode);
    final_report();
  end
endmodule : tb
